// File: usbd_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef USBD_CONSTS_SVH
`define USBD_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define USBD_OFS_CONTROL 8'hc1
`define USBD_OFS_POWERDOWN 8'hc2
`define USBD_OFS_IRQ_ENABLE 8'hc3
`define USBD_DEVICE_SELECT 8'h80

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define USBD_CTL_SPEED 7
`define USBD_CTL_ATTACHED 6
`define USBD_CTL_SOFT_RESET 5
`define USBD_CTL_SUSPEND 4
`define USBD_CTL_INIT 3
`define USBD_CTL_RESUME 2
`define USBD_CTL_CORE_CLK 1
`define USBD_CTL_PLL 0

// ----------------------------------------------------------------
// Power-down register fields
// ----------------------------------------------------------------
`define USBD_PD_TX 1
`define USBD_PD_RX 0

// ----------------------------------------------------------------
// Event positions, shared by enable and flag bytes
// ----------------------------------------------------------------
`define USBD_EV_SE0 7
`define USBD_EV_ATTACH 6
`define USBD_EV_DETACH 5
`define USBD_EV_SUSPEND_FLAG_BEGIN 4
`define USBD_EV_SUSPEND_FLAG_END 3
`define USBD_EV_STATUS 2
`define USBD_EV_SETUP 1
`define USBD_EV_SOF 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define USBD_RST_POWERDOWN 8'h00
`define USBD_RST_IRQ_ENABLE 8'h00
`define USBD_RST_FLAGS 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define USBD_CLK_MHZ 25
`define USBD_SE0_MIN_NS 2500
`define USBD_IDLE_MIN_NS 3000000
`define USBD_SE0_CYCLES ((`USBD_SE0_MIN_NS * `USBD_CLK_MHZ + 999) / 1000)
`define USBD_IDLE_CYCLES ((`USBD_IDLE_MIN_NS * `USBD_CLK_MHZ + 999) / 1000)
`define USBD_SWR_CYCLES 16
`define USBD_WAKE_CYCLES 25000

`endif

// File: usbd_pkg.sv
// Types shared by the device control block
package usbd_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usbd_sfr_t;

  typedef struct packed {
    logic se0;
    logic attach_pin;
    logic bus_idle;
    logic sof;
    logic status_end;
    logic setup_rx;
  } usbd_evt_t;

  typedef enum logic [0:0] {
    USBD_RUN = 1'b0,
    USBD_SWRESET = 1'b1
  } usbd_rst_state_t;

endpackage

// File: usbd_ctrl.sv
// USB device-level control, power-down and interrupt enable registers
//
// Contract
// - End of soft reset sets init pending
// - Resume request while suspended wakes the bus
// - Resume zero write ignored; auto-cleared unsuspended
// - Core clock enable gates core clock
// - PLL enable drives PLL, off after reset
// - Bit 1 powers down transmitter, reset zero
// - Bit 0 powers down receiver, blocks wake
// - Interrupt needs individual, group, global enables
// - Eight enables in fixed order, reset zero
// - Long single-ended zero raises reset event
// - Attach and detach each raise an event
// - Suspend entry and exit raise events
// - End of status phase raises event
// - Forwarded setup packet raises event
// - Start of frame raises event
// - Writing soft reset request starts reset
// - Speed bit zero low, one full
// - Suspend after 3 ms idle until activity
// - Registers answer only when select is 80
`include "usbd_consts.svh"

module usbd_ctrl #(
  parameter int IDLE_CYCLES = `USBD_IDLE_CYCLES,
  parameter int WAKE_CYCLES = `USBD_WAKE_CYCLES,
  parameter int SWR_CYCLES = `USBD_SWR_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire usbd_pkg::usbd_sfr_t i_sfr,
  input wire logic [7:0] i_endpoint_select,
  input wire usbd_pkg::usbd_evt_t i_evt,
  input wire logic [7:0] i_flag_clear,
  input wire logic i_group_irq_en,
  input wire logic i_global_irq_en,
  output logic [7:0] o_sfr_rdata,
  output logic o_full_speed,
  output logic o_core_clk_en,
  output logic o_pll_en,
  output logic o_tx_powerdown,
  output logic o_rx_powerdown,
  output logic o_bus_wake_en,
  output logic o_soft_reset,
  output logic o_suspend,
  output logic o_remote_wake,
  output logic [7:0] o_event_flags,
  output logic o_irq
);
  import usbd_pkg::*;

  localparam int SE0_CYCLES = `USBD_SE0_CYCLES;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  logic dev_sel;
  logic wr_ctl;
  logic wr_pd;
  logic wr_ien;
  logic rd_hit;
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction
  assign dev_sel = (i_endpoint_select == `USBD_DEVICE_SELECT);
  assign wr_ctl = i_sfr.wr && dev_sel && hit(i_sfr.addr, `USBD_OFS_CONTROL);
  assign wr_pd = i_sfr.wr && dev_sel && hit(i_sfr.addr, `USBD_OFS_POWERDOWN);
  assign wr_ien = i_sfr.wr && dev_sel && hit(i_sfr.addr, `USBD_OFS_IRQ_ENABLE);
  assign rd_hit = i_sfr.rd && dev_sel;

  // ----------------------------------------------------------------
  // Control register state
  // ----------------------------------------------------------------
  logic speed_reg;
  logic core_clk_reg;
  logic pll_reg;
  logic init_reg;
  logic resume_reg;
  logic suspend_reg;
  logic attach_reg;
  logic [7:0] pd_reg;
  logic [7:0] ien_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;

  // ----------------------------------------------------------------
  // Soft reset sequencer
  // ----------------------------------------------------------------
  usbd_rst_state_t rst_state_reg;
  logic [15:0] swr_cnt_reg;
  logic swr_done;
  assign swr_done = (rst_state_reg == USBD_SWRESET)
    && (swr_cnt_reg == 16'(SWR_CYCLES - 1));

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_state_reg <= USBD_RUN;
      swr_cnt_reg <= 16'h0000;
    end else begin
      unique case (rst_state_reg)
        USBD_RUN: begin
          swr_cnt_reg <= 16'h0000;
          if (wr_ctl && i_sfr.wdata[`USBD_CTL_SOFT_RESET]) begin
            rst_state_reg <= USBD_SWRESET;
          end
        end
        USBD_SWRESET: begin
          swr_cnt_reg <= swr_cnt_reg + 16'h0001;
          if (swr_done) begin
            rst_state_reg <= USBD_RUN;
          end
        end
      endcase
    end
  end

  // Speed can change only in the same write that requests a reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      speed_reg <= 1'b0;
    end else if (wr_ctl && i_sfr.wdata[`USBD_CTL_SOFT_RESET]) begin
      speed_reg <= i_sfr.wdata[`USBD_CTL_SPEED];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_clk_reg <= 1'b0;
      pll_reg <= 1'b0;
    end else if (wr_ctl) begin
      core_clk_reg <= i_sfr.wdata[`USBD_CTL_CORE_CLK];
      pll_reg <= i_sfr.wdata[`USBD_CTL_PLL];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_reg <= 1'b0;
    end else if (swr_done) begin
      init_reg <= 1'b1;
    end else if (wr_ctl && !i_sfr.wdata[`USBD_CTL_INIT]) begin
      init_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Suspend and resume
  // ----------------------------------------------------------------
  logic [31:0] idle_cnt_reg;
  logic [31:0] wake_cnt_reg;
  logic idle_long;
  logic resume_set;
  assign idle_long = (idle_cnt_reg == 32'(IDLE_CYCLES));
  assign resume_set = wr_ctl && i_sfr.wdata[`USBD_CTL_RESUME] && suspend_reg;

  // Counter saturates so a long idle does not wrap into a new entry
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_cnt_reg <= 32'h00000000;
    end else if (!i_evt.bus_idle || resume_set) begin
      idle_cnt_reg <= 32'h00000000;
    end else if (!idle_long) begin
      idle_cnt_reg <= idle_cnt_reg + 32'h00000001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      suspend_reg <= 1'b0;
    end else if (!i_evt.bus_idle || resume_set || resume_reg) begin
      suspend_reg <= 1'b0;
    end else if (idle_long) begin
      suspend_reg <= 1'b1;
    end
  end

  // Zero writes never touch the bit; it drops once suspend is gone
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resume_reg <= 1'b0;
    end else if (resume_set) begin
      resume_reg <= 1'b1;
    end else if (!suspend_reg) begin
      resume_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_cnt_reg <= 32'h00000000;
    end else if (resume_set) begin
      wake_cnt_reg <= 32'(WAKE_CYCLES);
    end else if (wake_cnt_reg != 32'h00000000) begin
      wake_cnt_reg <= wake_cnt_reg - 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Power-down and interrupt enable registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_reg <= `USBD_RST_POWERDOWN;
    end else if (wr_pd) begin
      pd_reg <= 8'h00;
      pd_reg[`USBD_PD_TX] <= i_sfr.wdata[`USBD_PD_TX];
      pd_reg[`USBD_PD_RX] <= i_sfr.wdata[`USBD_PD_RX];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ien_reg <= `USBD_RST_IRQ_ENABLE;
    end else if (wr_ien) begin
      ien_reg <= i_sfr.wdata;
    end
  end

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  logic [7:0] se0_cnt_reg;
  logic se0_hit;
  logic [7:0] evt;
  // Fires once per long SE0; short end-of-packet SE0 never reaches it
  assign se0_hit = i_evt.se0 && (se0_cnt_reg == 8'(SE0_CYCLES - 1));

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      se0_cnt_reg <= 8'h00;
    end else if (!i_evt.se0) begin
      se0_cnt_reg <= 8'h00;
    end else if (se0_cnt_reg != 8'(SE0_CYCLES)) begin
      se0_cnt_reg <= se0_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      attach_reg <= 1'b0;
    end else begin
      attach_reg <= i_evt.attach_pin;
    end
  end

  always_comb begin
    evt = 8'h00;
    evt[`USBD_EV_SE0] = se0_hit;
    evt[`USBD_EV_ATTACH] = i_evt.attach_pin && !attach_reg;
    evt[`USBD_EV_DETACH] = !i_evt.attach_pin && attach_reg;
    evt[`USBD_EV_SUSPEND_FLAG_BEGIN] = idle_long && !suspend_reg
      && i_evt.bus_idle && !resume_set && !resume_reg;
    evt[`USBD_EV_SUSPEND_FLAG_END] = suspend_reg
      && (!i_evt.bus_idle || resume_set || resume_reg);
    evt[`USBD_EV_STATUS] = i_evt.status_end;
    evt[`USBD_EV_SETUP] = i_evt.setup_rx;
    evt[`USBD_EV_SOF] = i_evt.sof;
  end

  // Set wins over a clear arriving in the same cycle
  assign flag_next = (flag_reg & ~i_flag_clear) | evt;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg <= `USBD_RST_FLAGS;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [7:0] ctl_view;
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[`USBD_CTL_SPEED] = speed_reg;
    ctl_view[`USBD_CTL_ATTACHED] = attach_reg;
    ctl_view[`USBD_CTL_SOFT_RESET] = (rst_state_reg == USBD_SWRESET);
    ctl_view[`USBD_CTL_SUSPEND] = suspend_reg;
    ctl_view[`USBD_CTL_INIT] = init_reg;
    ctl_view[`USBD_CTL_RESUME] = resume_reg;
    ctl_view[`USBD_CTL_CORE_CLK] = core_clk_reg;
    ctl_view[`USBD_CTL_PLL] = pll_reg;
  end

  // Read data is registered; unselected or unmapped reads give zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= 8'h00;
    end else if (!rd_hit) begin
      o_sfr_rdata <= 8'h00;
    end else begin
      unique case (i_sfr.addr)
        `USBD_OFS_CONTROL: o_sfr_rdata <= ctl_view;
        `USBD_OFS_POWERDOWN: o_sfr_rdata <= pd_reg;
        `USBD_OFS_IRQ_ENABLE: o_sfr_rdata <= ien_reg;
        default: o_sfr_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_full_speed <= 1'b0;
      o_core_clk_en <= 1'b0;
      o_pll_en <= 1'b0;
      o_tx_powerdown <= 1'b0;
      o_rx_powerdown <= 1'b0;
      o_bus_wake_en <= 1'b1;
      o_soft_reset <= 1'b0;
      o_suspend <= 1'b0;
      o_remote_wake <= 1'b0;
      o_event_flags <= `USBD_RST_FLAGS;
      o_irq <= 1'b0;
    end else begin
      o_full_speed <= speed_reg;
      o_core_clk_en <= core_clk_reg;
      o_pll_en <= pll_reg;
      o_tx_powerdown <= pd_reg[`USBD_PD_TX];
      o_rx_powerdown <= pd_reg[`USBD_PD_RX];
      o_bus_wake_en <= !pd_reg[`USBD_PD_RX];
      o_soft_reset <= (rst_state_reg == USBD_SWRESET);
      o_suspend <= suspend_reg;
      o_remote_wake <= (wake_cnt_reg != 32'h00000000);
      o_event_flags <= flag_reg;
      o_irq <= (|(flag_reg & ien_reg)) && i_group_irq_en
        && i_global_irq_en;
    end
  end

endmodule // usbd_ctrl

// File: usbd_host_model.sv
// Behavioural USB host that drives bus events into the device block
module usbd_host_model (
  input wire logic i_sys_clk,
  output usbd_pkg::usbd_evt_t o_evt
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbd_pkg::*;

  initial o_evt = '0;

  // Holds one bus condition for n cycles; short holds mimic end of packet
  task automatic hold(input int b, input int n);
    @(negedge i_sys_clk) o_evt[b] = 1'b1;
    repeat (n) @(negedge i_sys_clk);
    o_evt[b] = 1'b0;
  endtask

  task automatic level(input int b, input logic v);
    @(negedge i_sys_clk) o_evt[b] = v;
  endtask
endmodule // usbd_host_model

// File: usbd_ctrl_checker.sv
// Port-level assertions for the device control block
module usbd_ctrl_checker #(
  parameter int IDLE_CYCLES = 50,
  parameter int WAKE_CYCLES = 20,
  parameter int SWR_CYCLES = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire usbd_pkg::usbd_sfr_t i_sfr,
  input wire logic [7:0] i_endpoint_select,
  input wire usbd_pkg::usbd_evt_t i_evt,
  input wire logic i_group_irq_en,
  input wire logic i_global_irq_en,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_tx_powerdown,
  input wire logic o_rx_powerdown,
  input wire logic o_bus_wake_en,
  input wire logic o_soft_reset,
  input wire logic o_suspend,
  input wire logic o_remote_wake,
  input wire logic [7:0] o_event_flags,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  import usbd_pkg::*;
  logic [7:0] hi_cnt_reg;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Length of the running soft reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) hi_cnt_reg <= 8'h00;
    else hi_cnt_reg <= o_soft_reset ? hi_cnt_reg + 8'h01 : 8'h00;
  end

  sequence pd_wr;
    i_sfr.wr && i_endpoint_select == 8'h80 && i_sfr.addr == 8'hc2;
  endsequence
  sequence resume_wr;
    i_sfr.wr && i_endpoint_select == 8'h80 && i_sfr.addr == 8'hc1
      && i_sfr.wdata[2] && o_suspend;
  endsequence
  sequence woken;
    !o_suspend && o_remote_wake;
  endsequence

  pd_write_a: assert property (pd_wr |-> ##2
    {o_tx_powerdown, o_rx_powerdown} == $past(i_sfr.wdata[1:0], 2))
    else $error("power-down bits differ from written byte");
  wake_block_a: assert property (o_bus_wake_en == !o_rx_powerdown)
    else $error("bus wake enable disagrees with receiver power-down");
  select_gate_a: assert property (
    $past(i_sfr.rd && i_endpoint_select != 8'h80) |-> o_sfr_rdata == 8'h00)
    else $error("read answered while not selected");
  rdata_idle_a: assert property (!$past(i_sfr.rd) |-> o_sfr_rdata == 8'h00)
    else $error("read data present without a read");
  resume_wake_a: assert property (resume_wr |-> ##[1:3] woken)
    else $error("resume did not leave suspend with wake signalling");
  wake_hold_a: assert property (
    $rose(o_remote_wake) |-> o_remote_wake[*8])
    else $error("remote wake signalling too short");
  suspend_end_a: assert property (!i_evt.bus_idle |-> ##2 !o_suspend)
    else $error("suspend held while bus active");
  reset_len_a: assert property (
    $fell(o_soft_reset) |-> hi_cnt_reg == 8'(SWR_CYCLES))
    else $error("soft reset length wrong");
  sof_flag_a: assert property (i_evt.sof |-> ##2 o_event_flags[0])
    else $error("start of frame flag not set");
  irq_gate_a: assert property (
    (!(i_group_irq_en && i_global_irq_en))[*3] |-> !o_irq)
    else $error("interrupt while group or global enable off");
  irq_source_a: assert property (o_irq |->
    (o_event_flags | $past(o_event_flags)) != 8'h00)
    else $error("interrupt without any event flag");
endmodule // usbd_ctrl_checker

bind usbd_ctrl usbd_ctrl_checker #(
  .IDLE_CYCLES(IDLE_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES),
  .SWR_CYCLES(SWR_CYCLES)
) usbd_ctrl_checker_i (
  .i_sys_clk, .i_rst_n, .i_sfr, .i_endpoint_select, .i_evt,
  .i_group_irq_en, .i_global_irq_en, .o_sfr_rdata, .o_tx_powerdown,
  .o_rx_powerdown, .o_bus_wake_en, .o_soft_reset, .o_suspend,
  .o_remote_wake, .o_event_flags, .o_irq
);

// File: tb_usb_device_ctrl_power_irq_enable.sv
// Self-checking bench for the device control block
`include "usbd_consts.svh"
module tb_usb_device_ctrl_power_irq_enable;
  timeunit 1ns;
  timeprecision 1ps;
  import usbd_pkg::*;
  localparam int IDLE_N = 50;
  localparam int WAKE_N = 20;
  localparam int RSTL_N = 16;
  localparam int SE0 = 5, ATT = 4, IDL = 3, SOF = 2, STA = 1, SET = 0;
  logic i_sys_clk, i_rst_n, i_group_irq_en, i_global_irq_en;
  usbd_sfr_t i_sfr;
  usbd_evt_t i_evt;
  logic [7:0] i_endpoint_select, i_flag_clear, o_sfr_rdata, o_event_flags;
  logic o_full_speed, o_core_clk_en, o_pll_en, o_tx_powerdown;
  logic o_rx_powerdown, o_bus_wake_en, o_soft_reset, o_suspend;
  logic o_remote_wake, o_irq;
  int err_count = 0;
  int cmp_count = 0;
  int i;
  int hb[3] = '{SOF, STA, SET};
  int fb[3] = '{0, 2, 1};

  usbd_ctrl #(.IDLE_CYCLES(IDLE_N), .WAKE_CYCLES(WAKE_N),
    .SWR_CYCLES(RSTL_N)) usbd_ctrl_i (
    .i_sys_clk, .i_rst_n, .i_sfr, .i_endpoint_select, .i_evt,
    .i_flag_clear, .i_group_irq_en, .i_global_irq_en, .o_sfr_rdata,
    .o_full_speed, .o_core_clk_en, .o_pll_en, .o_tx_powerdown,
    .o_rx_powerdown, .o_bus_wake_en, .o_soft_reset, .o_suspend,
    .o_remote_wake, .o_event_flags, .o_irq);
  usbd_host_model usbd_host_model_i (.i_sys_clk, .o_evt(i_evt));

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Extra cycle lets the output flop follow the register
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    i_sfr.addr = a;
    i_sfr.wdata = d;
    i_sfr.wr = 1'b1;
    @(negedge i_sys_clk);
    i_sfr.wr = 1'b0;
    @(negedge i_sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_sys_clk);
    i_sfr.addr = a;
    i_sfr.rd = 1'b1;
    @(negedge i_sys_clk);
    i_sfr.rd = 1'b0;
    chk(o_sfr_rdata, exp);
  endtask
  task automatic clr();
    @(negedge i_sys_clk) i_flag_clear = 8'hff;
    @(negedge i_sys_clk) i_flag_clear = 8'h00;
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    i_rst_n = 1'b0;
    i_sfr = '0;
    i_endpoint_select = 8'h80;
    i_flag_clear = 8'h00;
    i_group_irq_en = 1'b1;
    i_global_irq_en = 1'b1;
    wait_n(6);
    i_rst_n = 1'b1;
    chk({o_pll_en, o_core_clk_en, o_tx_powerdown, o_rx_powerdown,
      o_bus_wake_en, o_full_speed, o_irq, o_suspend}, 8'h08);
    rd(8'hc1, 8'h00);
    rd(8'hc2, 8'h00);
    rd(8'hc3, 8'h00);
    rd(8'hc5, 8'h00);
    wr(8'hc2, 8'hff);
    rd(8'hc2, 8'h03);
    chk({6'h00, o_tx_powerdown, o_bus_wake_en}, 8'h02);
    wr(8'hc2, 8'h00);
    chk({6'h00, o_tx_powerdown, o_rx_powerdown}, 8'h00);
    i_endpoint_select = 8'h81;
    wr(8'hc3, 8'hff);
    rd(8'hc3, 8'h00);
    i_endpoint_select = 8'h80;
    rd(8'hc3, 8'h00);
    wr(8'hc3, 8'ha5);
    rd(8'hc3, 8'ha5);
    for (i = 0; i < 3; i++) begin
      wr(8'hc3, 8'h01 << fb[i]);
      usbd_host_model_i.hold(hb[i], 1);
      wait_n(3);
      chk(o_event_flags, 8'h01 << fb[i]);
      chk({7'h00, o_irq}, 8'h01);
      i_group_irq_en = 1'b0;
      wait_n(3);
      chk({7'h00, o_irq}, 8'h00);
      i_group_irq_en = 1'b1;
      i_global_irq_en = 1'b0;
      wait_n(3);
      chk({7'h00, o_irq}, 8'h00);
      i_global_irq_en = 1'b1;
      wr(8'hc3, ~(8'h01 << fb[i]));
      wait_n(2);
      chk({7'h00, o_irq}, 8'h00);
      clr();
    end
    usbd_host_model_i.hold(SE0, `USBD_SE0_CYCLES - 2);
    wait_n(3);
    chk(o_event_flags, 8'h00);
    usbd_host_model_i.hold(SE0, `USBD_SE0_CYCLES + 8);
    wait_n(3);
    chk(o_event_flags, 8'h80);
    clr();
    usbd_host_model_i.level(ATT, 1'b1);
    wait_n(3);
    chk(o_event_flags, 8'h40);
    rd(8'hc1, 8'h40);
    clr();
    usbd_host_model_i.level(ATT, 1'b0);
    wait_n(3);
    chk(o_event_flags, 8'h20);
    clr();
    usbd_host_model_i.level(IDL, 1'b1);
    wait_n(IDLE_N + 5);
    chk({7'h00, o_suspend}, 8'h01);
    chk(o_event_flags, 8'h10);
    wr(8'hc1, 8'h04);
    chk({6'h00, o_suspend, o_remote_wake}, 8'h01);
    wait_n(2);
    chk(o_event_flags, 8'h18);
    rd(8'hc1, 8'h00);
    usbd_host_model_i.level(IDL, 1'b0);
    wait_n(WAKE_N + 2);
    chk({7'h00, o_remote_wake}, 8'h00);
    clr();
    wr(8'hc1, 8'h04);
    rd(8'hc1, 8'h00);
    chk({7'h00, o_remote_wake}, 8'h00);
    wr(8'hc1, 8'ha0);
    chk({7'h00, o_soft_reset}, 8'h01);
    i = 0;
    while (o_soft_reset === 1'b1 && i < 100) begin
      wait_n(1);
      i++;
    end
    if (i == 100) begin
      $display("[ERR] %0t soft reset did not end", $time);
      err_count++;
      conclude();
    end
    wait_n(2);
    chk({7'h00, o_full_speed}, 8'h01);
    rd(8'hc1, 8'h88);
    // Init bytes go to the data port elsewhere; PLL follows its bit, speed holds without reset
    wr(8'hc1, 8'h83);
    rd(8'hc1, 8'h83);
    chk({6'h00, o_core_clk_en, o_pll_en}, 8'h03);
    wr(8'hc1, 8'h00);
    chk({5'h00, o_full_speed, o_core_clk_en, o_pll_en}, 8'h04);
    i_rst_n = 1'b0;
    wait_n(2);
    i_rst_n = 1'b1;
    rd(8'hc3, 8'h00);
    conclude();
  end
endmodule // tb_usb_device_ctrl_power_irq_enable
